// ---- testbench/iss_far_end.sv ----
/* serial side model: free running core clock, event pulses, received byte.
   assumes the bench calls pulse and give right after a clk edge. */
`timescale 1ns/10ps
`default_nettype none
module iss_far_end
  import iss_pkg::*;
(
  input  wire logic        clk,
  output var  logic        core_gen_clock,
  output var  iss_ev_s     ev,
  output var  logic [7:0]  rx_data,
  output var  logic [15:0] status_in
);
  // core clock runs free, 160 ns
  initial begin
    {core_gen_clock, ev, rx_data, status_in} = '0;
    forever #80 core_gen_clock = ~core_gen_clock;
  end
  // one-cycle event pulse
  task automatic pulse(input int i);
    ev <= iss_ev_s'(4'h1 << i);
    @(posedge clk);
    ev <= '0;
  endtask
  // new received byte
  task automatic give(input logic [7:0] b);
    rx_data <= b;
  endtask
endmodule // iss_far_end
`default_nettype wire

// ---- testbench/iss_regs_sva.sv ----
/* port checker for iss_regs.
   assumes only the top module's ports are visible. */
`timescale 1ns/10ps
`default_nettype none
module iss_regs_sva
  import iss_pkg::*;
(
  input wire logic     clk,
  input wire logic     rstn,
  input wire logic     avs_read,
  input wire logic     avs_write,
  input wire logic     avs_waitrequest,
  input wire logic     core_gen_clock,
  input wire logic     sleep_idle,
  input wire logic     sleep_standby,
  input wire logic     transfer_active,
  input wire iss_cfg_s cfg,
  input wire logic     core_enable,
  input wire logic     cmd_strobe,
  input wire logic     bstate_strobe,
  input wire logic     addr_strobe,
  input wire logic     wake,
  input wire logic     core_clk_req,
  input wire logic     rx_drop
);
  // ---------------------------
  // bus, clock, wake, drop, strobe and address checks
  // ---------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_idle_clock: assert property ((core_enable && sleep_idle && !sleep_standby)[*2] |-> core_clk_req)
    else $error("core clock off in idle");
  chk_stby_run: assert property ((core_enable && sleep_standby && cfg.standby_run)[*2] |-> core_clk_req)
    else $error("core clock off in standby");
  chk_xfer_hold: assert property ((core_enable && sleep_standby && cfg.mode == MODE_MASTER
    && transfer_active)[*2] |-> core_clk_req)
    else $error("core clock off mid transfer");
  chk_wake_cause: assert property (wake |-> $past(sleep_idle || sleep_standby))
    else $error("wake while awake");
  chk_wake_block: assert property ((sleep_standby && !sleep_idle && !cfg.standby_run
    && cfg.mode == MODE_SLAVE)[*2] |-> !wake)
    else $error("wake without standby run");
  chk_drop_stby: assert property (rx_drop |-> $past(sleep_standby) || $past(sleep_standby, 2))
    else $error("drop while awake");
  chk_sync_edge: assert property ((cmd_strobe || bstate_strobe || $changed(core_enable)) |->
    ($past(core_gen_clock, 2) || $past(core_gen_clock, 3) || $past(core_gen_clock, 4)))
    else $error("sync not on core edge");
  chk_strobe_one: assert property (cmd_strobe || bstate_strobe |=> !(cmd_strobe || bstate_strobe))
    else $error("strobe longer than one cycle");
  chk_addr_master: assert property (addr_strobe |-> cfg.mode == MODE_MASTER)
    else $error("address strobe in slave role");
endmodule // iss_regs_sva
bind iss_regs iss_regs_sva iss_regs_sva_i (.*);
`default_nettype wire

// ---- testbench/test_iss_regs.sv ----
/* self-checking bench for iss_regs.
   assumes the far-end model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module test_iss_regs;
  import iss_pkg::*;
  logic        clk, rstn, avs_read, avs_write, avs_waitrequest, sleep_idle, sleep_standby;
  logic        access_guard_on, transfer_active, core_gen_clock, core_enable, cmd_strobe;
  logic        data_strobe, irq, wake, core_clk_req, rx_drop;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q, cv, ctrl_b, own_addr;
  logic [1:0]  cmd, bus_state;
  logic [7:0]  tx_data, rx_data, b;
  logic [15:0] status_in;
  iss_ev_s     ev;
  iss_cfg_s    cfg;
  int          n_errors, comparisons, n_cmd, n_data;
  iss_far_end iss_far_end_i (.*);
  iss_regs iss_regs_i (.*, .bstate_strobe(), .addr_strobe());
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // strobe counters
  always @(posedge clk) begin
    if (cmd_strobe === 1'b1) n_cmd <= n_cmd + 1;
    if (data_strobe === 1'b1) n_data <= n_data + 1;
  end
  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  // one Avalon transfer, held until waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
    @(posedge clk);
  endtask
  // read of a whole register
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
  endtask
  // poll one sync_pending bit until clear
  task automatic sync_wait(input int k);
    int n = 0;
    do begin
      rd(IDX_SYNC_PEND);
      n++;
    end while (q[k] !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      complete_run();
    end
  endtask
  // soft reset, then wait out the sync
  task automatic soft_reset_bit();
    bus(1'b1, IDX_CONTROL_A, 32'h0000_0001, 4'h1);
    sync_wait(0);
    chk(q, 32'h0000_0000);
  endtask
  function automatic logic [31:0] fbit(input int i);
    return (i == 3) ? 32'h0000_0080 : 32'h0000_0001 << i;
  endfunction
  // main sequence
  initial begin
    {rstn, avs_read, avs_write, sleep_idle, sleep_standby, access_guard_on} = '0;
    {avs_address, avs_writedata, avs_byteenable, transfer_active} = '0;
    void'($urandom(70712));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(IDX_CONTROL_A);
    chk(q, CA_RESET);
    rd(6'h08);
    chk(q, 32'h0000_0000);
    // random slave setup, one byte lane at a time
    cv = $urandom() & CA_WMASK & 32'hffff_ff60;
    cv[4:2] = MODE_SLAVE;
    for (int i = 0; i < 4; i++) bus(1'b1, IDX_CONTROL_A, cv, 4'h1 << i);
    rd(IDX_CONTROL_A);
    chk(q, cv);
    chk(32'(cfg), 32'({cv[30], cv[27], cv[25:24], cv[23], cv[21:20], cv[16], cv[7], cv[4:2]}));
    access_guard_on <= 1'b1;
    bus(1'b1, IDX_CONTROL_A, cv ^ 32'h0300_0000, 4'hf);
    access_guard_on <= 1'b0;
    rd(IDX_CONTROL_A);
    chk(q, cv);
    bus(1'b1, IDX_CONTROL_A, cv | 32'h0000_0002, 4'h1);
    sync_wait(1);
    chk(32'(core_enable), 32'h0000_0001);
    bus(1'b1, IDX_CONTROL_A, cv ^ 32'h0010_0002, 4'hf);
    rd(IDX_CONTROL_A);
    chk(q, cv | 32'h0000_0002);
    bus(1'b1, IDX_CONTROL_B, 32'h0003_0000, 4'h4);
    sync_wait(2);
    chk(32'(n_cmd), 32'h0000_0001);
    chk(32'(cmd), 32'h0000_0003);
    chk(ctrl_b, 32'h0003_0000);
    // mask set and clear, then each event
    bus(1'b1, IDX_IRQ_EN_SET, 32'h0000_0087, 4'h1);
    bus(1'b1, IDX_IRQ_EN_CLR, 32'h0000_0004, 4'h1);
    rd(IDX_IRQ_EN_CLR);
    chk(q, 32'h0000_0083);
    for (int i = 0; i < 4; i++) begin
      iss_far_end_i.pulse(i);
      @(posedge clk);
      chk(32'(irq), 32'(i != 2));
      rd(IDX_IRQ_FLAGS);
      chk(q, fbit(i));
      chk(32'(irq), 32'h0000_0000);
    end
    // standby without standby_run drops receptions
    sleep_standby <= 1'b1;
    repeat (2) @(posedge clk);
    chk(32'(rx_drop), 32'h0000_0001);
    iss_far_end_i.pulse(1);
    repeat (2) @(posedge clk);
    chk(32'(wake), 32'h0000_0000);
    rd(IDX_IRQ_FLAGS);
    chk(q, 32'h0000_0000);
    sleep_standby <= 1'b0;
    sleep_idle <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(core_clk_req), 32'h0000_0001);
    sleep_idle <= 1'b0;
    b = 8'($urandom());
    iss_far_end_i.give(b);
    rd(IDX_DATA_PORT);
    chk(q, 32'(b));
    soft_reset_bit();
    rd(IDX_IRQ_EN_SET);
    chk(q, 32'h0000_0000);
    chk(32'(core_enable), 32'h0000_0000);
    // slave with standby_run wakes on address hit
    bus(1'b1, IDX_CONTROL_A, 32'h0000_0092, 4'h1);
    sync_wait(1);
    bus(1'b1, IDX_IRQ_EN_SET, 32'h0000_0002, 4'h1);
    sleep_standby <= 1'b1;
    iss_far_end_i.pulse(1);
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h0000_0001);
    chk(32'(core_clk_req), 32'h0000_0001);
    sleep_standby <= 1'b0;
    soft_reset_bit();
    // master: clock held through transfer, data and address synced
    bus(1'b1, IDX_CONTROL_A, 32'h0000_0016, 4'h1);
    sync_wait(1);
    transfer_active <= 1'b1;
    sleep_standby <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(core_clk_req), 32'h0000_0001);
    transfer_active <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(core_clk_req), 32'h0000_0000);
    sleep_standby <= 1'b0;
    bus(1'b1, IDX_DATA_PORT, 32'(b ^ 8'hff), 4'h1);
    sync_wait(2);
    chk(32'(tx_data), 32'(b ^ 8'hff));
    chk(32'(n_data), 32'h0000_0001);
    bus(1'b1, IDX_BUS_STATUS, 32'h0000_0010, 4'h1);
    chk(32'(bus_state), 32'h0000_0001);
    bus(1'b1, IDX_OWN_ADDR, 32'h0000_0054, 4'h3);
    sync_wait(2);
    chk(own_addr, 32'h0000_0054);
    bus(1'b1, IDX_IRQ_EN_SET, 32'h0000_0080, 4'h1);
    sleep_idle <= 1'b1;
    iss_far_end_i.pulse(3);
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h0000_0001);
    complete_run();
  end
endmodule // test_iss_regs
`default_nettype wire

// ---- verilog/iss_pkg.sv ----
/*
  constants, field layouts and carrier types for the two-wire target register front.
  assumes a 50 MHz system clock and an Avalon-MM master that uses word indexes as address.
*/
// How it works
// R1 - core clock stays on in idle sleep
// R2 - master with standby_run keeps core clock in standby
// R3 - master without standby_run stops after transfer ends
// R4 - master: any enabled interrupt wakes the system
// R5 - slave standby_run lets address_hit wake standby
// R6 - slave standby without standby_run drops all receptions
// R7 - reset, enable, command, bus state, master address synchronized
// R8 - master data writes synchronized into core domain
// R9 - byte and halfword access to every register
// R10 - control registers writable only while disabled; enable, soft reset and control_b command stay writable when enabled
// R11 - access guard blocks protected register writes
// R12 - control_a at index 0x00, resets to zero
// R13 - software selects target role with mode 0x04
// R14 - soft reset clears registers and disables unit
// R15 - enable clear and set registers edit mask
// R16 - sync_pending shows enable and reset in flight
// R17 - software waits for sync_pending clear
`default_nettype none
package iss_pkg;
  // --------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // --------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL_A  = 6'h00;
  localparam logic [5:0] IDX_CONTROL_B  = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN_CLR = 6'h14;
  localparam logic [5:0] IDX_IRQ_EN_SET = 6'h16;
  localparam logic [5:0] IDX_IRQ_FLAGS  = 6'h18;
  localparam logic [5:0] IDX_BUS_STATUS = 6'h1a;
  localparam logic [5:0] IDX_SYNC_PEND  = 6'h1c;
  localparam logic [5:0] IDX_OWN_ADDR   = 6'h24;
  localparam logic [5:0] IDX_DATA_PORT  = 6'h28;
  // --------------------------------------------------------------
  // control_a fields
  // --------------------------------------------------------------
  localparam int CA_SOFT_RESET_BIT     = 0;
  localparam int CA_ENABLE    = 1;
  localparam int CA_MODE_LSB  = 2;
  localparam int CA_STBY_RUN  = 7;
  localparam int CA_FOUR_WIRE = 16;
  localparam int CA_HOLD_LSB  = 20;
  localparam int CA_SEXT_EN   = 23;
  localparam int CA_SPEED_LSB = 24;
  localparam int CA_STRETCH   = 27;
  localparam int CA_LOWTO_EN  = 30;
  localparam logic [31:0] CA_WMASK   = 32'h4bb1_009f;
  localparam logic [31:0] CA_RESET   = 32'h0000_0000;
  localparam logic [2:0]  MODE_SLAVE  = 3'h4;
  localparam logic [2:0]  MODE_MASTER = 3'h5;
  // --------------------------------------------------------------
  // control_b, status, address and interrupt fields
  // --------------------------------------------------------------
  localparam int          CB_CMD_LSB   = 16;
  localparam logic [31:0] CB_WMASK     = 32'h0007_c700;
  localparam logic [31:0] CB_CMD_MASK  = 32'h0003_0000;
  localparam int          BS_STATE_LSB = 4;
  localparam logic [31:0] ADDR_WMASK   = 32'h07fe_87ff;
  localparam logic [7:0]  IRQ_MASK     = 8'h87;
  // --------------------------------------------------------------
  // sync_pending slots
  // --------------------------------------------------------------
  localparam int PD_SOFT_RESET_BIT  = 0;
  localparam int PD_ENABLE = 1;
  localparam int PD_CMD    = 2;
  localparam int PD_BSTATE = 3;
  localparam int PD_ADDR   = 4;
  localparam int PD_DATA   = 5;
  // --------------------------------------------------------------
  // carrier types
  // --------------------------------------------------------------
  typedef struct packed {
    logic error;
    logic byte_ready;
    logic address_hit;
    logic stop_seen;
  } iss_ev_s;
  typedef struct packed {
    logic       low_timeout_en;
    logic       stretch_mode;
    logic [1:0] speed;
    logic       slave_extend_timeout_en;
    logic [1:0] data_hold_sel;
    logic       four_wire_sel;
    logic       standby_run;
    logic [2:0] mode;
  } iss_cfg_s;
  typedef struct packed {
    logic [31:0] control_a;
    logic [31:0] control_b;
    logic [31:0] own_address;
    logic [7:0]  irq_mask;
    logic [7:0]  irq_flags;
    logic [1:0]  bus_state;
    logic [7:0]  data_reg;
    logic [5:0]  pend;
    logic [2:0]  link_sync;
    logic        core_enable;
    logic        cmd_strobe;
    logic        bstate_strobe;
    logic        addr_strobe;
    logic        data_strobe;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        irq;
    logic        wake;
    logic        core_clk_req;
    logic        rx_drop;
  } iss_state_s;
  localparam iss_state_s ST_RESET = '{waitrequest: 1'b1, default: '0};
endpackage
`default_nettype wire

// ---- verilog/iss_regs.sv ----
/*
  register front of the two-wire target unit: Avalon-MM slave, write synchronization
  toward the core clock, sleep clock requests, interrupt flags and wake.
  assumes serial events and rx data arrive on clk; core_gen_clock is a foreign clock.
*/
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
module iss_regs
  import iss_pkg::*;
(
  input  wire  logic        clk,             // system clock, 50 MHz
  input  wire  logic        rstn,            // synchronous reset, active low
  input  wire  logic [5:0]  avs_address,     // word index
  input  wire  logic        avs_read,        // read request
  input  wire  logic        avs_write,       // write request
  input  wire  logic [31:0] avs_writedata,   // write data
  input  wire  logic [3:0]  avs_byteenable,  // byte lanes
  output var   logic [31:0] avs_readdata,    // read data
  output var   logic        avs_waitrequest, // stall
  input  wire  logic        core_gen_clock,  // core generic clock, sampled
  input  wire  logic        sleep_idle,      // system in idle sleep
  input  wire  logic        sleep_standby,   // system in standby sleep
  input  wire  logic        access_guard_on, // write protection active
  input  wire  logic        transfer_active, // serial transfer ongoing
  input  wire  iss_ev_s     ev,              // one-cycle serial events
  input  wire  logic [7:0]  rx_data,         // received byte
  input  wire  logic [15:0] status_in,       // serial status bits
  output var   iss_cfg_s    cfg,             // control_a fields
  output var   logic [31:0] ctrl_b,          // control_b image
  output var   logic [31:0] own_addr,        // address register image
  output var   logic        core_enable,     // enable in core domain
  output var   logic        cmd_strobe,      // command taken
  output var   logic [1:0]  cmd,             // command value
  output var   logic        bstate_strobe,   // bus state taken
  output var   logic [1:0]  bus_state,       // bus state value
  output var   logic        addr_strobe,     // address taken
  output var   logic        data_strobe,     // data taken
  output var   logic [7:0]  tx_data,         // data to send
  output var   logic        irq,             // interrupt level
  output var   logic        wake,            // wake request
  output var   logic        core_clk_req,    // keep core clock on
  output var   logic        rx_drop          // receptions discarded
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // master role decode
  function automatic logic is_master(input logic [31:0] ca);
    return ca[CA_MODE_LSB +: 3] == MODE_MASTER;
  endfunction

  // slave role decode
  function automatic logic is_slave(input logic [31:0] ca);
    return ca[CA_MODE_LSB +: 3] == MODE_SLAVE;
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  iss_state_s  s;           // registered state
  iss_state_s  next_s;      // next state
  logic        req;         // bus request present
  logic        done;        // request completes this edge
  logic        wr;          // write takes effect
  logic        core_edge;   // core clock rising edge seen
  logic        locked;      // unit enabled
  logic        guarded;     // write protection active
  logic        drop;        // receptions dropped now
  logic [7:0]  flag_clr;    // flags cleared this edge
  logic [7:0]  flag_set;    // flags set this edge
  logic [7:0]  wake_sel;    // sources allowed to wake
  logic [31:0] wv;          // merged write value
  logic [31:0] rmux;        // read mux

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------

  // one pass builds the whole next state
  always_comb begin
    next_s    = s;
    req       = avs_read | avs_write;
    done      = req & ~s.waitrequest;
    wr        = done & avs_write & ~s.pend[PD_SOFT_RESET_BIT];
    locked    = s.control_a[CA_ENABLE] | s.core_enable;
    guarded   = access_guard_on;
    flag_clr  = 8'h00;
    wv        = 32'h0000_0000;
    rmux      = 32'h0000_0000;
    // core clock sampled through two flops, third for edge
    next_s.link_sync = {s.link_sync[1:0], core_gen_clock};
    core_edge        = s.link_sync[1] & ~s.link_sync[2];
    // strobes last one cycle
    next_s.cmd_strobe    = 1'b0;
    next_s.bstate_strobe = 1'b0;
    next_s.addr_strobe   = 1'b0;
    next_s.data_strobe   = 1'b0;

    // one wait cycle, then the answer
    next_s.waitrequest = ~(req & s.waitrequest);

    // read mux, loaded while waitrequest is high
    case (avs_address)
      IDX_CONTROL_A:  rmux = s.control_a;
      IDX_CONTROL_B:  rmux = s.control_b;
      IDX_IRQ_EN_CLR: rmux = {24'h00_0000, s.irq_mask};
      IDX_IRQ_EN_SET: rmux = {24'h00_0000, s.irq_mask};
      IDX_IRQ_FLAGS:  rmux = {24'h00_0000, s.irq_flags};
      IDX_BUS_STATUS: rmux = {16'h0000, status_in[15:6], s.bus_state, status_in[3:0]};
      IDX_SYNC_PEND:  rmux = {29'h0000_0000, |s.pend[PD_DATA:PD_CMD], s.pend[PD_ENABLE],
                              s.pend[PD_SOFT_RESET_BIT]}; // R16
      IDX_OWN_ADDR:   rmux = s.own_address;
      IDX_DATA_PORT:  rmux = {24'h00_0000, rx_data};
      default:        rmux = 32'h0000_0000;   // unmapped reads zero
    endcase
    if (req & s.waitrequest) begin
      next_s.readdata = rmux;
    end

    // core edge: pending writes take effect in the core domain
    if (core_edge) begin
      if (s.pend[PD_ENABLE]) begin
        next_s.core_enable     = s.control_a[CA_ENABLE];  // R7
        next_s.pend[PD_ENABLE] = 1'b0;                    // R16
      end
      if (s.pend[PD_CMD]) begin
        next_s.cmd_strobe   = 1'b1;                       // R7
        next_s.pend[PD_CMD] = 1'b0;
      end
      if (s.pend[PD_BSTATE]) begin
        next_s.bstate_strobe   = 1'b1;                    // R7
        next_s.pend[PD_BSTATE] = 1'b0;
      end
      if (s.pend[PD_ADDR]) begin
        next_s.addr_strobe   = 1'b1;                      // R7
        next_s.pend[PD_ADDR] = 1'b0;
      end
      if (s.pend[PD_DATA]) begin
        next_s.data_strobe   = 1'b1;                      // R8
        next_s.pend[PD_DATA] = 1'b0;
      end
    end

    // register writes
    if (wr) begin
      case (avs_address)
        IDX_CONTROL_A: begin
          if (!guarded) begin                                        // R11
            wv = merge(s.control_a, avs_writedata, avs_byteenable);  // R9
            if (wv[CA_SOFT_RESET_BIT]) begin
              // reset wins, the rest of the write is dropped
              next_s.control_a[CA_SOFT_RESET_BIT] = 1'b1;                     // R14
              next_s.pend[PD_SOFT_RESET_BIT]      = 1'b1;                     // R16
            end else begin
              if (!locked) begin
                next_s.control_a = wv & CA_WMASK;                    // R10
              end
              next_s.control_a[CA_SOFT_RESET_BIT]  = 1'b0;
              next_s.control_a[CA_ENABLE] = wv[CA_ENABLE];
              if (wv[CA_ENABLE] != s.control_a[CA_ENABLE]) begin
                next_s.pend[PD_ENABLE] = 1'b1;                       // R7
              end
            end
          end
        end
        IDX_CONTROL_B: begin
          if (!guarded) begin                                        // R11
            wv = merge(s.control_b, avs_writedata, avs_byteenable);  // R9
            if (locked) begin
              // command stays writable while running
              next_s.control_b = (s.control_b & ~CB_CMD_MASK) | (wv & CB_CMD_MASK); // R10
            end else begin
              next_s.control_b = wv & CB_WMASK;
            end
            if (avs_byteenable[2]) begin
              next_s.pend[PD_CMD] = 1'b1;                            // R7
            end
          end
        end
        IDX_IRQ_EN_CLR: begin
          if (avs_byteenable[0]) begin
            next_s.irq_mask = s.irq_mask & ~(avs_writedata[7:0] & IRQ_MASK); // R15
          end
        end
        IDX_IRQ_EN_SET: begin
          if (avs_byteenable[0]) begin
            next_s.irq_mask = s.irq_mask | (avs_writedata[7:0] & IRQ_MASK);  // R15
          end
        end
        IDX_IRQ_FLAGS: begin
          if (avs_byteenable[0]) begin
            flag_clr = avs_writedata[7:0];                           // one clears
          end
        end
        IDX_BUS_STATUS: begin
          if (avs_byteenable[0]) begin
            next_s.bus_state       = avs_writedata[BS_STATE_LSB +: 2];
            next_s.pend[PD_BSTATE] = 1'b1;                           // R7
          end
        end
        IDX_OWN_ADDR: begin
          next_s.own_address = merge(s.own_address, avs_writedata, avs_byteenable)
                               & ADDR_WMASK;                         // R9
          if (is_master(s.control_a)) begin
            next_s.pend[PD_ADDR] = 1'b1;                             // R7
          end
        end
        IDX_DATA_PORT: begin
          if (avs_byteenable[0]) begin
            next_s.data_reg = avs_writedata[7:0];
            if (is_master(s.control_a)) begin
              next_s.pend[PD_DATA] = 1'b1;                           // R8
            end else begin
              next_s.data_strobe = 1'b1;                             // slave: direct
            end
          end
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end

    // a completed read of the flag register clears it
    if (done & avs_read & (avs_address == IDX_IRQ_FLAGS)) begin
      flag_clr = IRQ_MASK;
    end

    // slave standby without standby_run drops receptions
    drop = is_slave(s.control_a) & sleep_standby & ~s.control_a[CA_STBY_RUN]; // R6
    flag_set = {ev.error, 4'h0, ev.byte_ready, ev.address_hit, ev.stop_seen}
               & {8{s.core_enable & ~drop}};                                   // R6
    // set wins over clear
    next_s.irq_flags = ((s.irq_flags & ~flag_clr) | flag_set) & IRQ_MASK;

    // wake sources: slave standby only by address hit
    if (is_slave(s.control_a) & sleep_standby) begin
      wake_sel = {6'h00, s.control_a[CA_STBY_RUN], 1'b0};                      // R5
    end else begin
      wake_sel = IRQ_MASK;                                                      // R4
    end

    // soft reset completes on a core edge
    if (core_edge & s.pend[PD_SOFT_RESET_BIT]) begin
      next_s             = ST_RESET;                                            // R14
      next_s.link_sync   = {s.link_sync[1:0], core_gen_clock};
      next_s.waitrequest = ~(req & s.waitrequest);
      next_s.readdata    = (req & s.waitrequest) ? CA_RESET : s.readdata;
    end

    // level outputs from the next state
    next_s.irq  = |(next_s.irq_flags & next_s.irq_mask);
    next_s.wake = (sleep_idle | sleep_standby)
                  & |(next_s.irq_flags & next_s.irq_mask & wake_sel);          // R4
    next_s.rx_drop = drop;
    // core clock: in idle while enabled or syncing, standby per role and standby_run
    next_s.core_clk_req = (next_s.core_enable | (|next_s.pend)) &
                          (~sleep_standby |                                     // R1
                           next_s.control_a[CA_STBY_RUN] |                      // R2
                           (is_master(next_s.control_a) & transfer_active) |    // R3
                           (|next_s.pend));
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------

  // synchronous reset to the documented reset values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= ST_RESET;  // R12
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------
  // outputs, straight from the state flops
  // --------------------------------------------------------------
  assign avs_readdata                = s.readdata;
  assign avs_waitrequest             = s.waitrequest;
  assign cfg.low_timeout_en          = s.control_a[CA_LOWTO_EN];
  assign cfg.stretch_mode            = s.control_a[CA_STRETCH];
  assign cfg.speed                   = s.control_a[CA_SPEED_LSB +: 2];
  assign cfg.slave_extend_timeout_en = s.control_a[CA_SEXT_EN];
  assign cfg.data_hold_sel           = s.control_a[CA_HOLD_LSB +: 2];
  assign cfg.four_wire_sel           = s.control_a[CA_FOUR_WIRE];
  assign cfg.standby_run             = s.control_a[CA_STBY_RUN];
  assign cfg.mode                    = s.control_a[CA_MODE_LSB +: 3];
  assign ctrl_b                      = s.control_b;
  assign own_addr                    = s.own_address;
  assign core_enable                 = s.core_enable;
  assign cmd_strobe                  = s.cmd_strobe;
  assign cmd                         = s.control_b[CB_CMD_LSB +: 2];
  assign bstate_strobe               = s.bstate_strobe;
  assign bus_state                   = s.bus_state;
  assign addr_strobe                 = s.addr_strobe;
  assign data_strobe                 = s.data_strobe;
  assign tx_data                     = s.data_reg;
  assign irq                         = s.irq;
  assign wake                        = s.wake;
  assign core_clk_req                = s.core_clk_req;
  assign rx_drop                     = s.rx_drop;

endmodule // iss_regs
`default_nettype wire
